// ---- inc/pmt_consts.svh ----
// offsets, field positions, reset values and timing counts of the timer
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH

// register byte offsets on the apb bus
`define PMT_OFF_CONTROL   12'h000
`define PMT_OFF_PERIOD    12'h004
`define PMT_OFF_COUNT     12'h008
`define PMT_OFF_STATUS    12'h00c
`define PMT_OFF_MASK      12'h010

// control field positions
`define PMT_PRE_LSB       0
`define PMT_RUN_BIT       2
`define PMT_POST_LSB      3

// reset values
`define PMT_CONTROL_RST   8'h00
`define PMT_PERIOD_RST    8'hff
`define PMT_COUNT_RST     8'h00

// instruction clock is a quarter of the oscillator
`define PMT_INSTR_DIV     4

`endif

// ---- inc/pmt_pkg.sv ----
// types shared by the timer design files
package pmt_pkg;

    // prescale divide selection
    typedef enum logic [1:0]
    {
        pmt_pre_1,
        pmt_pre_4,
        pmt_pre_16a,
        pmt_pre_16b
    } pmt_pre_e;

    // register selected by an apb address
    typedef enum logic [2:0]
    {
        pmt_reg_control,
        pmt_reg_period,
        pmt_reg_count,
        pmt_reg_status,
        pmt_reg_mask,
        pmt_reg_none
    } pmt_reg_e;

endpackage : pmt_pkg

// ---- rtl/pmt_prescaler.sv ----
// prescaler: divides the instruction tick by 1, 4 or 16
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.svh"

module pmt_prescaler
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control
    input  wire logic       clear,
    input  wire logic       tick_in,
    input  wire logic [1:0] select,
    // output pulse
    output logic            tick_out
);

    logic [3:0] count;
    logic [3:0] limit;

    // last count of the selected ratio
    always_comb
    begin
        unique case (pmt_pkg::pmt_pre_e'(select))
            pmt_pkg::pmt_pre_1:   limit = 4'h0;
            pmt_pkg::pmt_pre_4:   limit = 4'h3;
            pmt_pkg::pmt_pre_16a: limit = 4'hf;
            pmt_pkg::pmt_pre_16b: limit = 4'hf;
        endcase
    end

    // count instruction ticks, cleared by control or counter writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= 4'h0;
        else if (clear)
            count <= 4'h0;
        else if (tick_in)
            count <= (count >= limit) ? 4'h0 : count + 4'h1;
    end

    assign tick_out = tick_in && !clear && (count >= limit);

endmodule : pmt_prescaler

`default_nettype wire

// ---- rtl/pmt_postscaler.sv ----
// postscaler: one output pulse per select+1 match events
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.svh"

module pmt_postscaler
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // control
    input  wire logic       clear,
    input  wire logic       match,
    input  wire logic [3:0] select,
    // output pulse
    output logic            event_out
);

    logic [3:0] count;

    // count matches, wrapping at the selected ratio
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= 4'h0;
        else if (clear)
            count <= 4'h0;
        else if (match)
            count <= (count >= select) ? 4'h0 : count + 4'h1;
    end

    assign event_out = match && !clear && (count >= select);

endmodule : pmt_postscaler

`default_nettype wire

// ---- rtl/pmt_timer.sv ----
// period match timer with apb registers and masked interrupt
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.svh"

module pmt_timer
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    logic [6:0] timer_control;
    logic [7:0] period_value;
    logic [7:0] count_value;
    logic       peripheral_flag_register;
    logic       irq_mask;
    logic [1:0] instr_phase;
    logic       instr_tick;
    logic       pre_tick;
    logic       match;
    logic       post_event;
    logic       wr;
    logic       rd;
    logic       scaler_clear;
    pmt_pkg::pmt_reg_e sel_reg;

    // map an address onto a register
    function automatic pmt_pkg::pmt_reg_e decode(input logic [11:0] a);
        unique case (a)
            `PMT_OFF_CONTROL: decode = pmt_pkg::pmt_reg_control;
            `PMT_OFF_PERIOD:  decode = pmt_pkg::pmt_reg_period;
            `PMT_OFF_COUNT:   decode = pmt_pkg::pmt_reg_count;
            `PMT_OFF_STATUS:  decode = pmt_pkg::pmt_reg_status;
            `PMT_OFF_MASK:    decode = pmt_pkg::pmt_reg_mask;
            default:          decode = pmt_pkg::pmt_reg_none;
        endcase
    endfunction : decode

    // zero wait state slave; unmapped addresses answer with an error
    assign sel_reg = decode(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (sel_reg == pmt_pkg::pmt_reg_none);
    assign wr      = psel && penable && pwrite &&
                     (sel_reg != pmt_pkg::pmt_reg_none);
    assign rd      = psel && !pwrite;

    // scaler clear on control or counter write
    assign scaler_clear = wr &&
                          ((sel_reg == pmt_pkg::pmt_reg_control) ||
                           (sel_reg == pmt_pkg::pmt_reg_count));

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // control holds only seven bits, so bit 7 cannot be stored
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            timer_control <= 7'(`PMT_CONTROL_RST);
        else if (wr && sel_reg == pmt_pkg::pmt_reg_control)
            timer_control <= pwdata[6:0];
    end

    // period register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            period_value <= `PMT_PERIOD_RST;
        else if (wr && sel_reg == pmt_pkg::pmt_reg_period)
            period_value <= pwdata[7:0];
    end

    // interrupt mask
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask <= 1'b0;
        else if (wr && sel_reg == pmt_pkg::pmt_reg_mask)
            irq_mask <= pwdata[0];
    end

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    // instruction tick every fourth pclk, gated by run enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            instr_phase <= 2'h0;
        else
            instr_phase <= instr_phase + 2'h1;
    end

    assign instr_tick = (instr_phase == 2'(`PMT_INSTR_DIV - 1)) &&
                        timer_control[`PMT_RUN_BIT];

    pmt_prescaler u_pre
    (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (scaler_clear),
        .tick_in  (instr_tick),
        .select   (timer_control[`PMT_PRE_LSB +: 2]),
        .tick_out (pre_tick)
    );

    // match is evaluated on the increment that leaves the period value
    assign match = pre_tick && (count_value == period_value);

    // counter; a software write wins over counting, control writes keep it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_value <= `PMT_COUNT_RST;
        else if (wr && sel_reg == pmt_pkg::pmt_reg_count)
            count_value <= pwdata[7:0];
        else if (match)
            count_value <= 8'h00;
        else if (pre_tick)
            count_value <= count_value + 8'h01;
    end

    pmt_postscaler u_post
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .clear     (scaler_clear),
        .match     (match),
        .select    (timer_control[`PMT_POST_LSB +: 4]),
        .event_out (post_event)
    );

    // ------------------------------------------------------------
    // interrupt
    // ------------------------------------------------------------
    // sticky flag; a new event in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            peripheral_flag_register <= 1'b0;
        else if (post_event)
            peripheral_flag_register <= 1'b1;
        else if (wr && sel_reg == pmt_pkg::pmt_reg_status && pwdata[0])
            peripheral_flag_register <= 1'b0;
    end

    assign irq = peripheral_flag_register && irq_mask;

    // read data registered in setup so it is stable in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd && !penable)
        begin
            unique case (sel_reg)
                pmt_pkg::pmt_reg_control: prdata <= {25'h0, timer_control};
                pmt_pkg::pmt_reg_period:  prdata <= {24'h0, period_value};
                pmt_pkg::pmt_reg_count:   prdata <= {24'h0, count_value};
                pmt_pkg::pmt_reg_status:
                    prdata <= {31'h0, peripheral_flag_register};
                pmt_pkg::pmt_reg_mask:    prdata <= {31'h0, irq_mask};
                pmt_pkg::pmt_reg_none:    prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_period_reset;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> period_value == 8'hff;
    endproperty
    a_period_reset: assert property (p_period_reset)
        else $error("period not ff after reset");

    property p_wrap;
        @(posedge pclk) disable iff (!presetn)
        match && !wr |=> count_value == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap on match");

    property p_step;
        @(posedge pclk) disable iff (!presetn)
        pre_tick && !match && !wr
        |=> count_value == $past(count_value) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("counter did not step");

    property p_quarter;
        @(posedge pclk) disable iff (!presetn)
        instr_tick |=> !instr_tick [*3];
    endproperty
    a_quarter: assert property (p_quarter)
        else $error("instruction tick faster than a quarter");

    property p_stopped;
        @(posedge pclk) disable iff (!presetn)
        !timer_control[`PMT_RUN_BIT] |-> !match && !post_event;
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("activity while stopped");

    property p_ctl_keep;
        @(posedge pclk) disable iff (!presetn)
        wr && sel_reg == pmt_pkg::pmt_reg_control
        |=> count_value == $past(count_value);
    endproperty
    a_ctl_keep: assert property (p_ctl_keep)
        else $error("control write changed counter");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        post_event |=> peripheral_flag_register;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag not set by postscaler");

    property p_flag_hold;
        @(posedge pclk) disable iff (!presetn)
        peripheral_flag_register &&
        !(wr && sel_reg == pmt_pkg::pmt_reg_status && pwdata[0])
        |=> peripheral_flag_register;
    endproperty
    a_flag_hold: assert property (p_flag_hold)
        else $error("flag dropped without clear");

    property p_no_pre_in_clear;
        @(posedge pclk) disable iff (!presetn)
        scaler_clear |-> !pre_tick && !post_event;
    endproperty
    a_no_pre_in_clear: assert property (p_no_pre_in_clear)
        else $error("scaler output during clear");

endmodule : pmt_timer

`default_nettype wire

// ---- sim/tb.sv ----
// self-checking testbench of the period match timer
`timescale 1ns/1ps
`default_nettype none
`include "pmt_consts.svh"

module tb;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        pclk        = 1'b0;
    logic        presetn     = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq;
    logic        irq_d       = 1'b0;
    logic [31:0] rd;
    logic [31:0] v;
    logic        er;
    int          err_total   = 0;
    int          comparisons = 0;
    int          cyc         = 0;
    int          rises       = 0;
    int          rise_at     = 0;
    int          r0;

    // 10 MHz clock
    always #50 pclk = ~pclk;

    pmt_timer pmt_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

    // stamp each irq rise; the spacing of rises is free of tick phase
    always @(posedge pclk)
    begin
        cyc   <= cyc + 1;
        irq_d <= irq;
        if (irq === 1'b1 && irq_d !== 1'b1)
        begin
            rise_at <= cyc;
            rises   <= rises + 1;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic results;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : results

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one apb transfer; the request holds until pready is seen high
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            err_total++;
            results();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                         input string what);
        xfer(a, 1'b0, 32'h0);
        check(what, rd, e);
    endtask : rdchk

    // bounded wait for the next irq rise
    task automatic wait_rise;
        int n;
        int k;
        n = rises;
        k = 0;
        while (rises == n && k < 40000)
        begin
            @(posedge pclk);
            k++;
        end
        if (k >= 40000)
        begin
            err_total++;
            results();
        end
    endtask : wait_rise

    function automatic int ratio(input int code);
        return (code == 0) ? 1 : (code == 1) ? 4 : 16;
    endfunction : ratio

    // spacing of two flag events against the programmed divide chain
    task automatic measure(input int pre, input int post, input int per);
        wr(`PMT_OFF_CONTROL, 32'h0);
        wr(`PMT_OFF_COUNT, 32'h0);
        wr(`PMT_OFF_PERIOD, 32'(per));
        wr(`PMT_OFF_STATUS, 32'h1);
        wr(`PMT_OFF_MASK, 32'h1);
        wr(`PMT_OFF_CONTROL, 32'((post << 3) | 4 | pre));
        wait_rise();
        wr(`PMT_OFF_STATUS, 32'h1);
        r0 = rise_at;
        wait_rise();
        check("interval", 32'(rise_at - r0),
              32'((per + 1) * `PMT_INSTR_DIV * ratio(pre) * (post + 1)));
    endtask : measure

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hefc21e9e));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`PMT_OFF_CONTROL, 32'h0, "control");
        rdchk(`PMT_OFF_PERIOD, 32'hff, "period");
        rdchk(`PMT_OFF_COUNT, 32'h0, "count");
        rdchk(`PMT_OFF_STATUS, 32'h0, "status");
        xfer(12'h014, 1'b0, 32'h0);
        check("unmapped", rd, 32'h0);
        check("slverr", {31'h0, er}, 32'h1);
        // random register traffic with the timer stopped
        repeat (8)
        begin
            v = $urandom;
            wr(`PMT_OFF_CONTROL, v & 32'hffff_fffb);
            rdchk(`PMT_OFF_CONTROL, v & 32'h7b, "control");
            wr(`PMT_OFF_PERIOD, v >> 8);
            rdchk(`PMT_OFF_PERIOD, (v >> 8) & 32'hff, "period");
            wr(`PMT_OFF_COUNT, v >> 16);
            wr(`PMT_OFF_CONTROL, (v >> 24) & 32'hfb);
            repeat (100) @(posedge pclk);
            rdchk(`PMT_OFF_COUNT, (v >> 16) & 32'hff,
                  "count");
        end
        // writes closer than one prescale period keep the counter still
        wr(`PMT_OFF_COUNT, 32'h0);
        wr(`PMT_OFF_PERIOD, 32'hff);
        wr(`PMT_OFF_CONTROL, 32'h06);
        repeat (4)
        begin
            repeat (40) @(posedge pclk);
            wr(`PMT_OFF_COUNT, 32'h0);
            repeat (40) @(posedge pclk);
            wr(`PMT_OFF_CONTROL, 32'h06);
        end
        rdchk(`PMT_OFF_COUNT, 32'h0, "count");
        // corner ratios, then every prescale code with random figures
        measure(0, 15, 0);
        measure(3, 0, 3);
        for (int c = 0; c < 4; c++)
            measure(c, (c == 0) ? $urandom % 16 : $urandom % 4,
                    3 + $urandom % 5);
        // sticky flag, mask, and no events while stopped
        measure(0, 0, 3);
        repeat (40) @(posedge pclk);
        rdchk(`PMT_OFF_STATUS, 32'h1, "status");
        check("irq", {31'h0, irq}, 32'h1);
        wr(`PMT_OFF_MASK, 32'h0);
        check("irq", {31'h0, irq}, 32'h0);
        wr(`PMT_OFF_CONTROL, 32'h0);
        rdchk(`PMT_OFF_STATUS, 32'h1, "status");
        wr(`PMT_OFF_STATUS, 32'h1);
        wr(`PMT_OFF_MASK, 32'h1);
        repeat (100) @(posedge pclk);
        rdchk(`PMT_OFF_STATUS, 32'h0, "status");
        check("irq", {31'h0, irq}, 32'h0);
        // a reset in mid-run brings back the reset values
        wr(`PMT_OFF_PERIOD, 32'h5a);
        wr(`PMT_OFF_CONTROL, 32'h7f);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(`PMT_OFF_PERIOD, 32'hff, "period");
        rdchk(`PMT_OFF_CONTROL, 32'h0, "control");
        rdchk(`PMT_OFF_COUNT, 32'h0, "count");
        results();
    end
endmodule : tb
`default_nettype wire
